// >>> mbcod_bit_timer.sv
// reloadable interval timer giving one-cycle overflow pulses
`timescale 1ns/10ps
module mbcod_bit_timer
	import mbcod_pkg::*;
(
	input  wire logic             sys_clk_in,  // system clock
	input  wire logic             reset_in,    // async reset, high
	input  wire logic             reload_in,   // forced reload, holds count at zero
	input  wire logic [TMR_W-1:0] period_in,   // interval in clock cycles
	output logic                  ovf_out      // overflow pulse
);
	logic [TMR_W-1:0] cnt_ff;
	logic [TMR_W-1:0] last_cnt;

	// zero period behaves as one so the timer never stalls
	assign last_cnt = (period_in == '0) ? '0 : period_in - TMR_W'(1);

	// ****************************************
	// count and overflow
	// ****************************************
	// programmable interval timer
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_ff  <= '0;
			ovf_out <= 1'h0;
		end else if (reload_in) begin
			cnt_ff  <= '0;
			ovf_out <= 1'h0;
		end else if (cnt_ff >= last_cnt) begin
			cnt_ff  <= '0;
			ovf_out <= 1'h1;
		end else begin
			cnt_ff  <= cnt_ff + TMR_W'(1);
			ovf_out <= 1'h0;
		end
	end

	// a held reload never lets an overflow out
	hold_no_ovf_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		reload_in |=> !ovf_out) else $error("overflow while reload held");
endmodule // mbcod_bit_timer

// >>> mbcod_codec.sv
// manchester and biphase-mark line encoder and decoder, top level
// How it works
// - manchester one is mid-bit rising edge
// - manchester zero is mid-bit falling edge
// - two equal halves of opposite level
// - manchester line is data xor serial clock
// - bit value taken from second half
// - mid-bit transition starts three-eighths timer
// - clock rises first overflow, falls second, stops
// - latch line value at six eighths
// - line xor latch rises at mid-bit
// - timer runs from difference rise, six eighths
// - reload is nor of difference and clock
// - biphase line toggles each clock rise
// - biphase extra toggle mid-bit for one
// - toggle state loads data xor itself
// - half-rate clock xor toggle is line
// - biphase bit is xnor of samples
// - biphase timer bit start to six eighths
// - restart on line change from sample, stop on overflow
// - biphase clock is inverted reload
// - clear input zeroes toggle, decoder and overrun flip-flops (overrun unless a bit drops that cycle), not synchronisers, line outputs or stream path
`timescale 1ns/10ps
module mbcod_codec
	import mbcod_pkg::*;
(
	input  wire logic             sys_clk_in,       // system clock, 125 MHz
	input  wire logic             reset_in,         // async reset, high
	input  wire logic             ser_clk_in,       // serial clock pin from controller
	input  wire logic             ser_data_in,      // serial data pin from controller
	input  wire logic             mc_line_in,       // manchester line pin
	input  wire logic             bmc_line_in,      // biphase-mark line pin
	input  wire logic             flop_clear_in,    // clear codec flip-flops, high
	input  wire logic             line_mode_in,     // 0 manchester, 1 biphase into fifo
	input  wire logic [TMR_W-1:0] bit_cycles_in,    // bit time in clock cycles
	input  wire logic             rx_ready_in,      // stream sink ready
	output logic                  manchester_line_out, // manchester encoded line
	output logic                  bmc_line_out,     // biphase-mark encoded line
	output logic                  mc_sck_out,       // recovered manchester clock
	output logic                  mc_data_out,      // decoded manchester bit
	output logic                  bmc_sck_out,      // recovered biphase clock
	output logic                  bmc_data_out,     // decoded biphase bit
	output logic                  rx_valid_out,     // stream word valid
	output logic [DATA_W-1:0]     rx_data_out,      // stream decoded bit
	output logic                  overrun_out       // bit lost to full fifo, sticky
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;

	assign pins_raw = {line_mode_in, flop_clear_in, bmc_line_in, mc_line_in,
		ser_data_in, ser_clk_in};

	// two stages per pin, first stage read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge sys_clk_in or posedge reset_in) begin
				if (reset_in) begin
					sync1_ff[gi] <= RST_LEVEL;
					sync2_ff[gi] <= RST_LEVEL;
				end else begin
					sync1_ff[gi] <= pins_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	logic sck_s;
	logic sdat_s;
	logic mc_s;
	logic bmc_s;
	logic clr_s;
	logic mode_s;
	assign sck_s  = sync2_ff[PIN_SCK];
	assign sdat_s = sync2_ff[PIN_SDAT];
	assign mc_s   = sync2_ff[PIN_MC];
	assign bmc_s  = sync2_ff[PIN_BMC];
	assign clr_s  = sync2_ff[PIN_CLR];
	assign mode_s = sync2_ff[PIN_MODE];

	// ****************************************
	// encoders
	// ****************************************
	logic sck_prev_ff;
	logic sck_rise;
	logic sck_fall;
	logic toggle_state_ff;
	logic half_rate_clock_ff;

	assign sck_rise = sck_s && !sck_prev_ff;
	assign sck_fall = !sck_s && sck_prev_ff;

	// edge history of the serial clock
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sck_prev_ff <= 1'h0;
		end else begin
			sck_prev_ff <= sck_s;
		end
	end

	// xor gives one/zero as rising/falling mid-bit edge
	// idle-low clock with stable data makes equal halves
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			manchester_line_out <= 1'h0;
		end else begin
			manchester_line_out <= sdat_s ^ sck_s;
		end
	end

	// toggle on falling clock for data one
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			toggle_state_ff <= 1'h0;
		end else if (clr_s) begin
			toggle_state_ff <= 1'h0;
		end else if (sck_fall) begin
			toggle_state_ff <= sdat_s ^ toggle_state_ff;
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			half_rate_clock_ff <= 1'h0;
		end else if (clr_s) begin
			half_rate_clock_ff <= 1'h0;
		end else if (sck_rise) begin
			half_rate_clock_ff <= !half_rate_clock_ff;
		end
	end

	// boundary toggle plus mid-bit toggle for one
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bmc_line_out <= 1'h0;
		end else begin
			bmc_line_out <= half_rate_clock_ff ^ toggle_state_ff;
		end
	end

	toggle_one_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		sck_fall && sdat_s && !clr_s |=> toggle_state_ff != $past(toggle_state_ff))
		else $error("toggle state did not flip for one");
	toggle_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		sck_fall && !sdat_s && !clr_s |=> $stable(toggle_state_ff))
		else $error("toggle state moved for zero");
	half_rate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		sck_rise && !clr_s |=> ##1 bmc_line_out != $past(bmc_line_out))
		else $error("biphase line missed boundary toggle");
	mc_enc_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		$rose(sck_s) && sdat_s |=> !manchester_line_out)
		else $error("manchester line not low in first half of a one");

	// ****************************************
	// decoder intervals
	// ****************************************
	logic [TMR_W-1:0] mc_period;
	logic [TMR_W-1:0] bmc_period;
	logic [TMR_W+2:0] mc_prod;
	logic [TMR_W+2:0] bmc_prod;

	// three and six eighths of the bit time
	assign mc_prod    = (TMR_W+3)'(bit_cycles_in) * (TMR_W+3)'(MC_NUM_EIGHTHS);
	assign bmc_prod   = (TMR_W+3)'(bit_cycles_in) * (TMR_W+3)'(BMC_NUM_EIGHTHS);
	assign mc_period  = TMR_W'(mc_prod >> EIGHTHS_SHIFT);
	assign bmc_period = TMR_W'(bmc_prod >> EIGHTHS_SHIFT);

	// ****************************************
	// manchester decoder
	// ****************************************
	logic latched_line_value_ff;
	logic mc_diff;
	logic mc_reload;
	logic mc_ovf;
	logic mc_push;

	// difference is zero after capture, rises mid-bit
	assign mc_diff   = mc_s ^ latched_line_value_ff;
	// reload is nor of difference and clock
	assign mc_reload = !(mc_diff || mc_sck_out);

	mbcod_bit_timer u_mc_timer (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.reload_in  (mc_reload),
		.period_in  (mc_period),
		.ovf_out    (mc_ovf)
	);

	// first overflow raises clock, second drops it
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mc_sck_out <= 1'h0;
		end else if (clr_s) begin
			mc_sck_out <= 1'h0;
		end else if (mc_ovf) begin
			mc_sck_out <= !mc_sck_out;
		end
	end

	// latch at second overflow, ends the run
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			latched_line_value_ff <= 1'h0;
		end else if (clr_s) begin
			latched_line_value_ff <= 1'h0;
		end else if (mc_ovf && mc_sck_out) begin
			latched_line_value_ff <= mc_s;
		end
	end

	// bit taken in the second half at first overflow
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mc_data_out <= 1'h0;
		end else if (clr_s) begin
			mc_data_out <= 1'h0;
		end else if (mc_ovf && !mc_sck_out) begin
			mc_data_out <= mc_s;
		end
	end
	assign mc_push = mc_ovf && !mc_sck_out && !clr_s;

	mc_clk_rise_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		mc_ovf && !mc_sck_out && !clr_s |=> mc_sck_out && mc_data_out == $past(mc_s))
		else $error("manchester clock or bit wrong at first overflow");
	mc_latch_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		mc_ovf && mc_sck_out && !clr_s |=> !mc_sck_out
		&& latched_line_value_ff == $past(mc_s))
		else $error("manchester latch or clock wrong at second overflow");
	mc_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		!mc_diff && !mc_sck_out |=> !mc_ovf)
		else $error("manchester timer ran while reloaded");

	// ****************************************
	// biphase-mark decoder
	// ****************************************
	mbcod_bmc_state_t bmc_state_ff;
	logic prior_sample_ff;
	logic current_sample_ff;
	logic bmc_reload;
	logic bmc_ovf;
	logic bmc_push;

	assign bmc_reload = (bmc_state_ff != MBCOD_RUN);

	// timer from bit start to six eighths
	mbcod_bit_timer u_bmc_timer (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.reload_in  (bmc_reload),
		.period_in  (bmc_period),
		.ovf_out    (bmc_ovf)
	);

	// a line change after the sample restarts, overflow stops
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bmc_state_ff <= MBCOD_WAIT;
		end else if (clr_s) begin
			bmc_state_ff <= MBCOD_WAIT;
		end else begin
			case (bmc_state_ff)
				MBCOD_WAIT: begin
					if (bmc_s != current_sample_ff) begin
						bmc_state_ff <= MBCOD_RUN;
					end
				end
				MBCOD_RUN: begin
					if (bmc_ovf) begin
						bmc_state_ff <= MBCOD_WAIT;
					end
				end
				default: begin
					bmc_state_ff <= MBCOD_WAIT;
				end
			endcase
		end
	end

	// samples at six eighths, bit is their xnor
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			prior_sample_ff   <= 1'h0;
			current_sample_ff <= 1'h0;
			bmc_data_out      <= 1'h0;
		end else if (clr_s) begin
			prior_sample_ff   <= 1'h0;
			current_sample_ff <= 1'h0;
			bmc_data_out      <= 1'h0;
		end else if (bmc_ovf && bmc_state_ff == MBCOD_RUN) begin
			prior_sample_ff   <= current_sample_ff;
			current_sample_ff <= bmc_s;
			bmc_data_out      <= !(bmc_s ^ current_sample_ff);
		end
	end
	assign bmc_push = bmc_ovf && (bmc_state_ff == MBCOD_RUN) && !clr_s;

	// registered copy of the run state; falls at six eighths
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bmc_sck_out <= 1'h0;
		end else begin
			bmc_sck_out <= !bmc_reload;
		end
	end

	bmc_data_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		bmc_push |=> bmc_data_out == !($past(bmc_s) ^ $past(current_sample_ff)))
		else $error("biphase bit not xnor of samples");
	bmc_clk_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		$rose(bmc_sck_out) |-> $past(bmc_s, 2) != $past(current_sample_ff, 2))
		else $error("biphase clock rose without a bit boundary");

	// ****************************************
	// decoded bit stream
	// ****************************************
	mbcod_stream_if #(.W(DATA_W)) push_if ();
	mbcod_stream_if #(.W(DATA_W)) pop_if ();

	// mode selects which decoder fills the fifo
	assign push_if.valid = mode_s ? bmc_push : mc_push;
	assign push_if.data  = DATA_W'(mode_s ? !(bmc_s ^ current_sample_ff) : mc_s);

	mbcod_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.wr         (push_if.snk),
		.rd         (pop_if.src)
	);

	// output register stalls the fifo drain while it holds a word the sink is not ready for
	assign pop_if.ready = !rx_valid_out || rx_ready_in;
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_valid_out <= 1'h0;
			rx_data_out  <= '0;
		end else if (pop_if.ready) begin
			rx_valid_out <= pop_if.valid;
			rx_data_out  <= pop_if.data;
		end
	end

	// line bits cannot wait, so a full fifo drops and flags; set beats clear
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			overrun_out <= 1'h0;
		end else if (push_if.valid && !push_if.ready) begin
			overrun_out <= 1'h1;
		end else if (clr_s) begin
			overrun_out <= 1'h0;
		end
	end

	clear_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		clr_s |=> !toggle_state_ff && !half_rate_clock_ff && !latched_line_value_ff
		&& !mc_sck_out) else $error("codec flop not cleared");
endmodule // mbcod_codec

// >>> mbcod_codec_bench.sv
// self-checking bench for the manchester and biphase-mark codec
`timescale 1ns/10ps
module mbcod_codec_bench
	import mbcod_pkg::*;
();
	// ****************************************
	// signals
	// ****************************************
	localparam int    HALF  = 16;         // half a bit in sys cycles
	localparam int    LIMIT = 20000;      // run needs about 3300 cycles
	logic             sys_clk_in    = 1'b0;
	logic             reset_in      = 1'b1;
	logic             flop_clear_in = 1'b0;
	logic             line_mode_in  = 1'b0;
	logic             rx_ready_in   = 1'b0;
	logic [TMR_W-1:0] bit_cycles_in = 16'h0020;
	logic             stall         = 1'b0;
	logic             last_bit      = 1'b0;
	logic             ref_bmc       = 1'b0;
	wire logic        ser_clk_in, ser_data_in, manchester_line_out, bmc_line_out;
	wire logic        mc_sck_out, mc_data_out, bmc_sck_out, bmc_data_out;
	wire logic        rx_valid_out, overrun_out;
	wire logic [DATA_W-1:0] rx_data_out;
	int               mc_bits, bmc_bits;
	int               seed      = 36;
	int               error_cnt = 0;
	int               tests_run = 0;
	int               cyc       = 0;
	logic             exp_q[$];

	// ****************************************
	// instances, line outputs looped back
	// ****************************************
	mbcod_codec i_dut (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ser_clk_in(ser_clk_in),
		.ser_data_in(ser_data_in), .mc_line_in(manchester_line_out),
		.bmc_line_in(bmc_line_out), .flop_clear_in(flop_clear_in),
		.line_mode_in(line_mode_in), .bit_cycles_in(bit_cycles_in),
		.rx_ready_in(rx_ready_in), .manchester_line_out(manchester_line_out),
		.bmc_line_out(bmc_line_out), .mc_sck_out(mc_sck_out), .mc_data_out(mc_data_out),
		.bmc_sck_out(bmc_sck_out), .bmc_data_out(bmc_data_out),
		.rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .overrun_out(overrun_out)
	);

	mbcod_ctrl_model #(.HALF(HALF)) i_ctrl (
		.sys_clk_in(sys_clk_in), .mc_sck_in(mc_sck_out), .bmc_sck_in(bmc_sck_out),
		.ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in),
		.mc_bits_out(mc_bits), .bmc_bits_out(bmc_bits)
	);

	// ****************************************
	// clock, timeout, sink
	// ****************************************
	always #4 sys_clk_in = ~sys_clk_in;

	// a hang ends in the same closing report
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			end_of_test();
		end
	end

	// random sink readiness keeps the fifo exercised
	always @(posedge sys_clk_in) begin
		#1;
		rx_ready_in = stall ? 1'b0 : 1'($random(seed));
	end

	// each taken word is matched against the oldest note
	always @(posedge sys_clk_in) begin
		if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
			check(32'(rx_data_out), (exp_q.size() > 0) ? 32'(exp_q.pop_front()) : 32'h2);
	end

	// line levels checked mid-way through each half bit
	always @(posedge ser_clk_in or negedge ser_clk_in) begin
		if (reset_in === 1'b0) begin
			if (ser_clk_in || ser_data_in)
				ref_bmc = ~ref_bmc;
			repeat (HALF / 2) @(posedge sys_clk_in);
			#2;
			check(32'(manchester_line_out), 32'(ser_data_in ^ ser_clk_in));
			check(32'(bmc_line_out), 32'(ref_bmc));
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// first bit forced to one so the manchester receiver locks mid-bit
	task automatic send(input int keep);
		logic [31:0] bits;
		int          i;
		bits = $random(seed);
		bits[0] = 1'b1;
		last_bit = bits[31];
		for (i = 0; i < keep; i++)
			exp_q.push_back(bits[i]);
		i_ctrl.send_frame(bits);
	endtask

	task automatic drain();
		int n;
		stall = 1'b0;
		for (n = 0; n < 400 && exp_q.size() > 0; n++)
			@(posedge sys_clk_in);
		repeat (40) @(posedge sys_clk_in);
		#1;
		check(32'(exp_q.size()), 32'h0);
	endtask

	task automatic do_reset(input logic mode);
		reset_in = 1'b1;
		i_ctrl.rest();
		ref_bmc = 1'b0;
		line_mode_in = mode;
		repeat (16) @(posedge sys_clk_in);
		#1;
		reset_in = 1'b0;
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		do_reset(1'b0);
		// manchester frame into a randomly stalling sink
		send(32);
		drain();
		check(32'(mc_bits), 32'h20);
		check(32'({mc_data_out, bmc_data_out}), 32'({2{last_bit}}));
		// biphase frame, then one into a stalled sink that overflows
		do_reset(1'b1);
		send(32);
		drain();
		check(32'(bmc_data_out), 32'(last_bit));
		stall = 1'b1;
		// output register holds one word beyond the fifo depth
		send(FIFO_DEPTH + 1);
		check(32'(overrun_out), 32'h1);
		drain();
		check(32'(rx_valid_out), 32'h0);
		check(32'(bmc_bits), 32'h60);
		// clearing the codec flops
		flop_clear_in = 1'b1;
		repeat (8) @(posedge sys_clk_in);
		#1;
		check(32'(overrun_out), 32'h0);
		check(32'({mc_sck_out, bmc_sck_out, mc_data_out, bmc_data_out, bmc_line_out}), 32'h0);
		flop_clear_in = 1'b0;
		end_of_test();
	end
endmodule // mbcod_codec_bench

// >>> mbcod_ctrl_model.sv
// serial controller model: drives clock and data, counts recovered clock periods
`timescale 1ns/10ps
module mbcod_ctrl_model
	import mbcod_pkg::*;
#(
	parameter int HALF = 16              // sys cycles per half bit
) (
	input  wire logic sys_clk_in,        // system clock
	input  wire logic mc_sck_in,         // recovered manchester clock
	input  wire logic bmc_sck_in,        // recovered biphase clock
	output logic      ser_clk_out,       // serial clock to codec
	output logic      ser_data_out,      // serial data to codec
	output int        mc_bits_out,       // manchester bits taken
	output int        bmc_bits_out       // biphase bits taken
);
	// ****************************************
	// transmit side
	// ****************************************
	// the clock stands still outside frames
	initial begin
		ser_clk_out  = 1'b0;
		ser_data_out = 1'b0;
		mc_bits_out  = 0;
		bmc_bits_out = 0;
	end

	// idle-low clock, data on first edge
	task automatic send_frame(input logic [31:0] bits);
		int i;
		@(posedge sys_clk_in);
		#1;
		for (i = 0; i < 32; i++) begin
			ser_data_out = bits[i];    // lsb first
			ser_clk_out  = 1'b1;
			repeat (HALF) @(posedge sys_clk_in);
			#1;
			ser_clk_out = 1'b0;        // data holds across the fall
			repeat (HALF) @(posedge sys_clk_in);
			#1;
		end
	endtask

	// parking data low only under reset, else a manchester receiver sees a stray edge
	task automatic rest();
		ser_data_out = 1'b0;
	endtask

	// ****************************************
	// receive side
	// ****************************************
	logic mc_hi_seen  = 1'b0;
	logic bmc_hi_seen = 1'b0;

	// a fall counts only after a real high, the power-up x-to-0 is no edge
	always @(posedge mc_sck_in) mc_hi_seen = 1'b1;
	always @(posedge bmc_sck_in) bmc_hi_seen = 1'b1;

	// take each bit on the second clock edge
	always @(negedge mc_sck_in) begin
		if (mc_hi_seen)
			mc_bits_out++;
	end

	always @(negedge bmc_sck_in) begin
		if (bmc_hi_seen)
			bmc_bits_out++;
	end
endmodule // mbcod_ctrl_model

// >>> mbcod_fifo.sv
// synchronous valid/ready fifo for decoded bits
`timescale 1ns/10ps
module mbcod_fifo
	import mbcod_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic   sys_clk_in,  // system clock
	input  wire logic   reset_in,    // async reset, high
	mbcod_stream_if.snk wr,          // filling side
	mbcod_stream_if.src rd           // draining side
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             do_wr;
	logic             do_rd;

	// ****************************************
	// flags and handshakes
	// ****************************************
	assign wr.ready = (count_ff != (AW+1)'(DEPTH));
	assign rd.valid = (count_ff != '0);
	assign rd.data  = mem[rd_ptr_ff];
	assign do_wr    = wr.valid && wr.ready;
	assign do_rd    = rd.valid && rd.ready;

	// storage has no reset, only pointers and count do
	always_ff @(posedge sys_clk_in) begin
		if (do_wr) begin
			mem[wr_ptr_ff] <= wr.data;
		end
	end

	// pointers wrap naturally, depth is a power of two
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= wr_ptr_ff + AW'(1);
			end
			if (do_rd) begin
				rd_ptr_ff <= rd_ptr_ff + AW'(1);
			end
			count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	fifo_bound_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		count_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
	fifo_full_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(count_ff == (AW+1)'(DEPTH)) |-> !wr.ready) else $error("ready while full");
endmodule // mbcod_fifo

// >>> mbcod_pkg.sv
// shared constants for the manchester and biphase-mark codec
package mbcod_pkg;
	// ****************************************
	// clock and bit timing
	// ****************************************
	localparam int          CLK_PERIOD_NS  = 8;
	localparam int          BIT_TIME_NS    = 8000;
	localparam int          BIT_CYC_DFLT   = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int          TMR_W          = 16;
	localparam int          EIGHTHS_SHIFT  = 3;
	localparam int          MC_NUM_EIGHTHS = 3;
	localparam int          BMC_NUM_EIGHTHS = 6;
	// ****************************************
	// pin synchroniser and stream path
	// ****************************************
	localparam int          SYNC_W         = 6;
	localparam int          PIN_SCK        = 0;
	localparam int          PIN_SDAT       = 1;
	localparam int          PIN_MC         = 2;
	localparam int          PIN_BMC        = 3;
	localparam int          PIN_CLR        = 4;
	localparam int          PIN_MODE       = 5;
	localparam int          DATA_W         = 1;
	localparam int          FIFO_DEPTH     = 16;
	localparam logic        RST_LEVEL      = 1'h0;
	// ****************************************
	// biphase decoder states
	// ****************************************
	typedef enum logic [1:0] {
		MBCOD_WAIT = 2'h0,
		MBCOD_RUN  = 2'h1
	} mbcod_bmc_state_t;
endpackage

// >>> mbcod_stream_if.sv
// valid/ready stream carrier between codec modules
`timescale 1ns/10ps
interface mbcod_stream_if #(parameter int W = 1) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // mbcod_stream_if
